// [include/dms_pkg.sv]
// ============================================================================
// dms_pkg: constants shared by the dual mode sequencer design files
// ============================================================================
// holds register offsets, setup field positions, mode layouts and reset values
// assumes an 8-bit register port that is already decoded from the serial link
package dms_pkg;

  // ==========================================================================
  // register map (byte offsets on the 8-bit register port)
  // ==========================================================================
  localparam logic [7:0] DMS_RCV_SETUP_OFS = 8'h18;
  localparam logic [7:0] DMS_LO_SETUP_OFS = 8'h19;
  localparam logic [7:0] DMS_RCV_STATE_FIRST_OFS = 8'h1A;
  localparam logic [7:0] DMS_RCV_STATE_LAST_OFS = 8'h21;
  localparam logic [7:0] DMS_LO_STATE_FIRST_OFS = 8'h22;
  localparam logic [7:0] DMS_LO_STATE_LAST_OFS = 8'h29;
  localparam logic [7:0] DMS_SOFT_PULSE_OFS = 8'h2A;
  localparam logic [7:0] DMS_STATUS_OFS = 8'h3E;
  localparam logic [7:0] DMS_RCV_MODE_FIRST_OFS = 8'h40;
  localparam logic [7:0] DMS_RCV_MODE_LAST_OFS = 8'h6F;
  localparam logic [7:0] DMS_LO_MODE_FIRST_OFS = 8'h70;
  localparam logic [7:0] DMS_LO_MODE_LAST_OFS = 8'h7F;

  // ==========================================================================
  // setup register fields (same layout for both sequencers)
  // ==========================================================================
  localparam int DMS_DEPTH_LSB = 0;
  localparam int DMS_DEPTH_W = 4;
  localparam int DMS_LATCH_BYPASS_BIT = 4;
  localparam int DMS_SLEEP_HOLD_BIT = 5;
  localparam int DMS_SLEEP_LINK_BIT = 6;
  localparam int DMS_ENABLE_BIT = 7;
  localparam logic [7:0] DMS_SETUP_RESET = 8'h00;

  // soft pulse register bits
  localparam int DMS_LO_SOFT_RESET_BIT = 3;
  localparam int DMS_LO_SOFT_ADVANCE_BIT = 2;
  localparam int DMS_RCV_SOFT_RESET_BIT = 1;
  localparam int DMS_RCV_SOFT_ADVANCE_BIT = 0;
  localparam logic [7:0] DMS_SOFT_PULSE_MASK = 8'h0F;

  // ==========================================================================
  // sequencer geometry
  // ==========================================================================
  localparam int DMS_NUM_MODES = 16;
  localparam int DMS_NUM_STATES = 16;
  localparam int DMS_PTR_W = 5;
  localparam int DMS_RCV_MODE_BYTES = 3;
  localparam logic [4:0] DMS_STATE_ZERO = 5'h00;
  localparam logic [4:0] DMS_STATE_ONE = 5'h01;

  // ==========================================================================
  // local oscillator mode layout: buffer, three band pairs, filter
  // ==========================================================================
  localparam int DMS_LO_BUF_BIT = 0;
  localparam int DMS_LO_BAND_LSB = 1;
  localparam int DMS_LO_FILTER_BIT = 7;
  localparam int DMS_LO_BANDS = 3;

  // power-up contents of the sixteen local oscillator modes
  localparam logic [7:0] DMS_LO_MODE_SLEEP = 8'h00;
  localparam logic [7:0] DMS_LO_MODE_READY = 8'h2B;
  localparam logic [7:0] DMS_LO_MODE_SWEEP0 = 8'hFA;
  localparam logic [7:0] DMS_LO_MODE_SWEEP1 = 8'h7A;
  localparam logic [7:0] DMS_LO_MODE_SWEEP2 = 8'hEE;
  localparam logic [7:0] DMS_LO_MODE_SWEEP3 = 8'h6E;
  localparam logic [7:0] DMS_LO_MODE_SWEEP4 = 8'hEB;
  localparam logic [7:0] DMS_LO_MODE_SWEEP5 = 8'h6B;
  localparam logic [127:0] DMS_LO_MODE_INIT = {64'h0,
    DMS_LO_MODE_SWEEP5, DMS_LO_MODE_SWEEP4, DMS_LO_MODE_SWEEP3, DMS_LO_MODE_SWEEP2,
    DMS_LO_MODE_SWEEP1, DMS_LO_MODE_SWEEP0, DMS_LO_MODE_READY, DMS_LO_MODE_SLEEP};
  localparam logic [383:0] DMS_RCV_MODE_INIT = 384'h0;

endpackage

// [hdl/dms_pin_edge.sv]
// ============================================================================
// dms_pin_edge: three-stage synchroniser with edge pulses for one pin
// ============================================================================
// the pin is asynchronous to clk_i; pulses must last several clock periods
`timescale 1ns/10ps
module dms_pin_edge (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic pin_i,
  output logic rise_o,
  output logic fall_o
);

  logic [2:0] sync_q;
  logic [2:0] sync_d;
  logic level_q;
  logic level_d;
  logic rise_q;
  logic rise_d;
  logic fall_q;
  logic fall_d;

  // a change counts only when stages two and three agree
  always_comb begin
    sync_d = {sync_q[1:0], pin_i};
    level_d = level_q;
    rise_d = 1'b0;
    fall_d = 1'b0;
    if (sync_q[1] == sync_q[2] && sync_q[2] != level_q) begin
      level_d = sync_q[2];
      rise_d = sync_q[2];
      fall_d = ~sync_q[2];
    end
  end

  // registers only
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync_q <= 3'h0;
      level_q <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      sync_q <= sync_d;
      level_q <= level_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
    end
  end

  assign rise_o = rise_q;
  assign fall_o = fall_q;

endmodule

// [hdl/dms_mode_mem.sv]
// ============================================================================
// dms_mode_mem: mode storage with byte writes and two registered read ports
// ============================================================================
// port a feeds the sequencer lookup, port b the register readback
`timescale 1ns/10ps
module dms_mode_mem #(
  parameter int DEPTH = 16,
  parameter int BYTES = 1,
  parameter logic [DEPTH*BYTES*8-1:0] INIT = '0
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic wr_en_i,
  input wire logic [3:0] wr_idx_i,
  input wire logic [BYTES-1:0] wr_be_i,
  input wire logic [7:0] wr_data_i,
  input wire logic [3:0] a_idx_i,
  output logic [BYTES*8-1:0] a_data_o,
  input wire logic [3:0] b_idx_i,
  output logic [BYTES*8-1:0] b_data_o
);

  localparam int W = BYTES * 8;

  logic [W-1:0] mem_q [DEPTH];
  logic [W-1:0] mem_d [DEPTH];
  logic [W-1:0] a_q;
  logic [W-1:0] b_q;

  if (DEPTH != 16 || BYTES < 1) begin : g_bad
    $error("dms_mode_mem needs sixteen entries and at least one byte");
  end

  // byte-lane write into the addressed entry
  always_comb begin
    for (int e = 0; e < DEPTH; e++) begin
      mem_d[e] = mem_q[e];
      for (int b = 0; b < BYTES; b++) begin
        if (wr_en_i && wr_be_i[b] && wr_idx_i == e[3:0]) begin
          mem_d[e][b*8 +: 8] = wr_data_i;
        end
      end
    end
  end

  // contents come up from the constant image, read data are registered
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int e = 0; e < DEPTH; e++) begin
        mem_q[e] <= INIT[e*W +: W];
      end
      a_q <= '0;
      b_q <= '0;
    end else begin
      mem_q <= mem_d;
      a_q <= mem_q[a_idx_i];
      b_q <= mem_q[b_idx_i];
    end
  end

  assign a_data_o = a_q;
  assign b_data_o = b_q;

endmodule

// [hdl/dms_sequencer_top.sv]
// ============================================================================
// dms_sequencer_top: local oscillator and receiver mode sequencers
// ============================================================================
// assumes an 8-bit register port already decoded from the serial link and
// four pulse pins from an outside array controller, asynchronous to clk_i
//
// How it works
// - lo depth field is zero indexed: loop holds field plus one states
// - latched mode: load on pulse rising edge, apply on its falling edge
// - latch bypass applies the new state right after the rising edge
// - lo sleep hold stops lo advancing while forced asleep by receiver
// - lo sleep link forces lo to sleep while receiver sits in state 0
// - lo pins act only while the lo enable bit is high
// - receiver setup mirrors lo setup layout at its own offset
// - each state holds a four-bit mode pointer; state 0 always mode 0
// - lo state pointers fill eight registers, state 1 in first upper nibble
// - receiver state pointers fill eight registers, state 1 upper nibble
// - a reset pulse moves the pointer to state 0 at any time
// - advance steps by one; past the last state wraps to state 1
// - soft pulse bits 3 and 2 reset and advance the lo sequencer
// - soft pulse bits 1 and 0 reset and advance the receiver sequencer
// - sixteen writable lo modes, mode 0 included
// - receiver modes take three registers each, mode 0 first
// - each loop may hold up to sixteen states
// - lo modes power up with sleep, ready and six sweep modes
// - sleep hold ignores pin and soft advances but always obeys reset
// - lo mode: buffer, ready/active pair per band, filter bit
`timescale 1ns/10ps
module dms_sequencer_top
  import dms_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic lo_reset_pin_i,
  input wire logic lo_advance_pin_i,
  input wire logic rcv_reset_pin_i,
  input wire logic rcv_advance_pin_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_we_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_re_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  output logic [7:0] lo_ctrl_o,
  output logic [dms_pkg::DMS_LO_BANDS-1:0] lo_band_active_o,
  output logic [dms_pkg::DMS_LO_BANDS-1:0] lo_band_sleep_o,
  output logic [23:0] rcv_ctrl_o
);

  import dms_pkg::*;

  // ==========================================================================
  // pin edge detection (index 0 lo, 1 receiver; reset/advance per index)
  // ==========================================================================
  logic [1:0] pin_rst;
  logic [1:0] pin_adv;
  logic [1:0] rst_rise;
  logic [1:0] rst_fall;
  logic [1:0] adv_rise;
  logic [1:0] adv_fall;

  assign pin_rst = {rcv_reset_pin_i, lo_reset_pin_i};
  assign pin_adv = {rcv_advance_pin_i, lo_advance_pin_i};

  for (genvar p = 0; p < 2; p++) begin : g_pin
    dms_pin_edge u_rst (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .pin_i(pin_rst[p]),
      .rise_o(rst_rise[p]),
      .fall_o(rst_fall[p])
    );
    dms_pin_edge u_adv (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .pin_i(pin_adv[p]),
      .rise_o(adv_rise[p]),
      .fall_o(adv_fall[p])
    );
  end

  // ==========================================================================
  // register file
  // ==========================================================================
  logic [7:0] setup_q [2];
  logic [7:0] setup_d [2];
  logic [3:0] state_mode_q [2][DMS_NUM_STATES];
  logic [3:0] state_mode_d [2][DMS_NUM_STATES];
  logic [3:0] soft_q;
  logic [3:0] soft_d;
  logic in_lo_state;
  logic in_rcv_state;
  logic in_rcv_mode;
  logic in_lo_mode;
  logic [7:0] rcv_mode_ofs;
  logic [3:0] rcv_mode_idx;
  logic [2:0] rcv_mode_be;
  logic [3:0] state_reg_idx;

  assign in_lo_state = reg_addr_i >= DMS_LO_STATE_FIRST_OFS
                       && reg_addr_i <= DMS_LO_STATE_LAST_OFS;
  assign in_rcv_state = reg_addr_i >= DMS_RCV_STATE_FIRST_OFS
                        && reg_addr_i <= DMS_RCV_STATE_LAST_OFS;
  assign in_rcv_mode = reg_addr_i >= DMS_RCV_MODE_FIRST_OFS
                       && reg_addr_i <= DMS_RCV_MODE_LAST_OFS;
  assign in_lo_mode = reg_addr_i >= DMS_LO_MODE_FIRST_OFS
                      && reg_addr_i <= DMS_LO_MODE_LAST_OFS;
  assign rcv_mode_ofs = reg_addr_i - DMS_RCV_MODE_FIRST_OFS;
  assign rcv_mode_idx = 4'(rcv_mode_ofs / 8'd3);
  assign rcv_mode_be = 3'h1 << (rcv_mode_ofs % 8'd3);
  assign state_reg_idx = in_lo_state ? 4'(reg_addr_i - DMS_LO_STATE_FIRST_OFS)
                                     : 4'(reg_addr_i - DMS_RCV_STATE_FIRST_OFS);

  // register writes; the soft pulse bits clear themselves a cycle later
  always_comb begin
    setup_d = setup_q;
    state_mode_d = state_mode_q;
    soft_d = 4'h0;
    if (reg_we_i) begin
      if (reg_addr_i == DMS_RCV_SETUP_OFS) begin
        setup_d[1] = reg_wdata_i;
      end
      if (reg_addr_i == DMS_LO_SETUP_OFS) begin
        setup_d[0] = reg_wdata_i;
      end
      // lo state pairs, odd state in upper nibble
      if (in_lo_state) begin
        state_mode_d[0][{state_reg_idx[2:0], 1'b0}] = reg_wdata_i[7:4];
        state_mode_d[0][{state_reg_idx[2:0], 1'b1}] = reg_wdata_i[3:0];
      end
      if (in_rcv_state) begin
        state_mode_d[1][{state_reg_idx[2:0], 1'b0}] = reg_wdata_i[7:4];
        state_mode_d[1][{state_reg_idx[2:0], 1'b1}] = reg_wdata_i[3:0];
      end
      if (reg_addr_i == DMS_SOFT_PULSE_OFS) begin
        soft_d = reg_wdata_i[3:0];
      end
    end
  end

  // registers only; state_mode index k holds state k+1
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      setup_q <= '{default: DMS_SETUP_RESET};
      state_mode_q <= '{default: '{default: 4'h0}};
      soft_q <= 4'h0;
    end else begin
      setup_q <= setup_d;
      state_mode_q <= state_mode_d;
      soft_q <= soft_d;
    end
  end

  // ==========================================================================
  // sequencer pointers (index 0 lo, 1 receiver)
  // ==========================================================================
  logic [DMS_PTR_W-1:0] ptr_q [2];
  logic [DMS_PTR_W-1:0] ptr_d [2];
  logic [DMS_PTR_W-1:0] applied_q [2];
  logic [DMS_PTR_W-1:0] applied_d [2];
  logic [1:0] soft_rst;
  logic [1:0] soft_adv;
  logic [1:0] soft_fall_q;
  logic [1:0] soft_fall_d;
  logic [1:0] forced_sleep;
  logic [3:0] mode_idx [2];

  assign soft_rst = {soft_q[DMS_RCV_SOFT_RESET_BIT], soft_q[DMS_LO_SOFT_RESET_BIT]};
  assign soft_adv = {soft_q[DMS_RCV_SOFT_ADVANCE_BIT], soft_q[DMS_LO_SOFT_ADVANCE_BIT]};

  // sleep link: a partner sitting in state 0 forces this side asleep
  assign forced_sleep[0] = setup_q[0][DMS_SLEEP_LINK_BIT] && applied_q[1] == DMS_STATE_ZERO;
  assign forced_sleep[1] = setup_q[1][DMS_SLEEP_LINK_BIT] && applied_q[0] == DMS_STATE_ZERO;

  for (genvar s = 0; s < 2; s++) begin : g_seq
    logic en;
    logic rst_ev;
    logic adv_ev;
    logic fall_ev;
    logic hold;
    logic [DMS_PTR_W-1:0] last;

    assign en = setup_q[s][DMS_ENABLE_BIT];
    // pin and soft request merge into one event
    assign rst_ev = (en && rst_rise[s]) || soft_rst[s];
    assign adv_ev = (en && adv_rise[s]) || soft_adv[s];
    assign fall_ev = (en && (rst_fall[s] || adv_fall[s])) || soft_fall_q[s];
    // hold blocks advances while forced asleep
    assign hold = setup_q[s][DMS_SLEEP_HOLD_BIT] && forced_sleep[s];
    // last loop state is depth field plus one
    assign last = DMS_PTR_W'(setup_q[s][DMS_DEPTH_LSB +: DMS_DEPTH_W]) + DMS_STATE_ONE;

    // next pointer and the state handed to the mode lookup
    always_comb begin
      ptr_d[s] = ptr_q[s];
      applied_d[s] = applied_q[s];
      soft_fall_d[s] = soft_rst[s] | soft_adv[s];
      if (rst_ev) begin
        ptr_d[s] = DMS_STATE_ZERO;
      end else if (adv_ev && !hold) begin
        // wrap back to state 1, never to state 0
        if (ptr_q[s] >= last) begin
          ptr_d[s] = DMS_STATE_ONE;
        end else begin
          ptr_d[s] = ptr_q[s] + DMS_STATE_ONE;
        end
      end
      // bypass applies at once after the rising edge
      if (setup_q[s][DMS_LATCH_BYPASS_BIT]) begin
        applied_d[s] = ptr_d[s];
      end else if (fall_ev) begin
        // latched update on the falling edge
        applied_d[s] = ptr_q[s];
      end
    end

    // state 0 always selects mode 0
    assign mode_idx[s] = (applied_q[s] == DMS_STATE_ZERO) ? 4'h0
                         : state_mode_q[s][4'(applied_q[s] - DMS_STATE_ONE)];
  end

  // registers only
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ptr_q <= '{default: DMS_STATE_ZERO};
      applied_q <= '{default: DMS_STATE_ZERO};
      soft_fall_q <= 2'h0;
    end else begin
      ptr_q <= ptr_d;
      applied_q <= applied_d;
      soft_fall_q <= soft_fall_d;
    end
  end

  // ==========================================================================
  // mode storage
  // ==========================================================================
  logic [7:0] lo_mode_rd;
  logic [7:0] lo_mode_bus;
  logic [23:0] rcv_mode_rd;
  logic [23:0] rcv_mode_bus;

  // writable lo modes with power-up image
  dms_mode_mem #(
    .DEPTH(DMS_NUM_MODES),
    .BYTES(1),
    .INIT(DMS_LO_MODE_INIT)
  ) u_lo_modes (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .wr_en_i(reg_we_i && in_lo_mode),
    .wr_idx_i(reg_addr_i[3:0]),
    .wr_be_i(1'b1),
    .wr_data_i(reg_wdata_i),
    .a_idx_i(mode_idx[0]),
    .a_data_o(lo_mode_rd),
    .b_idx_i(reg_addr_i[3:0]),
    .b_data_o(lo_mode_bus)
  );

  // receiver modes, three byte lanes each
  dms_mode_mem #(
    .DEPTH(DMS_NUM_MODES),
    .BYTES(DMS_RCV_MODE_BYTES),
    .INIT(DMS_RCV_MODE_INIT)
  ) u_rcv_modes (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .wr_en_i(reg_we_i && in_rcv_mode),
    .wr_idx_i(rcv_mode_idx),
    .wr_be_i(rcv_mode_be),
    .wr_data_i(reg_wdata_i),
    .a_idx_i(mode_idx[1]),
    .a_data_o(rcv_mode_rd),
    .b_idx_i(rcv_mode_idx),
    .b_data_o(rcv_mode_bus)
  );

  // ==========================================================================
  // control outputs and register readback
  // ==========================================================================
  logic [7:0] lo_ctrl_q;
  logic [7:0] lo_ctrl_d;
  logic [DMS_LO_BANDS-1:0] band_act_q;
  logic [DMS_LO_BANDS-1:0] band_act_d;
  logic [DMS_LO_BANDS-1:0] band_slp_q;
  logic [DMS_LO_BANDS-1:0] band_slp_d;
  logic [23:0] rcv_ctrl_q;
  logic [23:0] rcv_ctrl_d;
  logic [7:0] rd_addr_q;
  logic rd_pend_q;
  logic [2:0] rd_be_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic rvalid_q;

  // forced sleep drives all controls low; bands decode from lo_ctrl_d
  always_comb begin
    lo_ctrl_d = forced_sleep[0] ? 8'h00 : lo_mode_rd;
    rcv_ctrl_d = forced_sleep[1] ? 24'h000000 : rcv_mode_rd;
    // band sleeps with neither bit, active only with both
    for (int b = 0; b < DMS_LO_BANDS; b++) begin
      band_act_d[b] = &lo_ctrl_d[DMS_LO_BAND_LSB + 2*b +: 2];
      band_slp_d[b] = ~|lo_ctrl_d[DMS_LO_BAND_LSB + 2*b +: 2];
    end
  end

  // readback mux one cycle behind the memory port; unmapped reads give zero
  always_comb begin
    rdata_d = 8'h00;
    if (rd_addr_q == DMS_RCV_SETUP_OFS) begin
      rdata_d = setup_q[1];
    end else if (rd_addr_q == DMS_LO_SETUP_OFS) begin
      rdata_d = setup_q[0];
    end else if (rd_addr_q >= DMS_RCV_STATE_FIRST_OFS
                 && rd_addr_q <= DMS_LO_STATE_LAST_OFS) begin
      for (int k = 0; k < 16; k++) begin
        if (rd_addr_q == DMS_RCV_STATE_FIRST_OFS + 8'(k)) begin
          rdata_d = {state_mode_q[1-k/8][(k%8)*2], state_mode_q[1-k/8][(k%8)*2+1]};
        end
      end
    end else if (rd_addr_q == DMS_STATUS_OFS) begin
      rdata_d = {applied_q[0][3:0], applied_q[1][3:0]};
    end else if (rd_addr_q >= DMS_RCV_MODE_FIRST_OFS
                 && rd_addr_q <= DMS_RCV_MODE_LAST_OFS) begin
      for (int b = 0; b < 3; b++) begin
        if (rd_be_q[b]) begin
          rdata_d = rcv_mode_bus[b*8 +: 8];
        end
      end
    end else if (rd_addr_q >= DMS_LO_MODE_FIRST_OFS && rd_addr_q <= DMS_LO_MODE_LAST_OFS) begin
      rdata_d = lo_mode_bus;
    end
  end

  // registers only; soft pulse register reads zero as the readback mux has no entry for it
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lo_ctrl_q <= 8'h00;
      band_act_q <= '0;
      band_slp_q <= '1;
      rcv_ctrl_q <= 24'h000000;
      rd_addr_q <= 8'h00;
      rd_pend_q <= 1'b0;
      rd_be_q <= 3'h0;
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      lo_ctrl_q <= lo_ctrl_d;
      band_act_q <= band_act_d;
      band_slp_q <= band_slp_d;
      rcv_ctrl_q <= rcv_ctrl_d;
      rd_addr_q <= reg_addr_i;
      rd_pend_q <= reg_re_i;
      rd_be_q <= rcv_mode_be;
      rdata_q <= rd_pend_q ? rdata_d : 8'h00;
      rvalid_q <= rd_pend_q;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign reg_rvalid_o = rvalid_q;
  assign lo_ctrl_o = lo_ctrl_q;
  assign lo_band_active_o = band_act_q;
  assign lo_band_sleep_o = band_slp_q;
  assign rcv_ctrl_o = rcv_ctrl_q;

endmodule

// [test/dms_seq_checker.sv]
// ===========================================================================
// dms_seq_checker: port assertions for the dual mode sequencer top
// ===========================================================================
// assumes one clock domain; bound to dms_sequencer_top below
`timescale 1ns/10ps
module dms_seq_checker
  import dms_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic lo_reset_pin_i,
  input wire logic lo_advance_pin_i,
  input wire logic rcv_reset_pin_i,
  input wire logic rcv_advance_pin_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_we_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_re_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire logic [7:0] lo_ctrl_o,
  input wire logic [dms_pkg::DMS_LO_BANDS-1:0] lo_band_active_o,
  input wire logic [dms_pkg::DMS_LO_BANDS-1:0] lo_band_sleep_o,
  input wire logic [23:0] rcv_ctrl_o
);
  logic [7:0] lo_setup_q;
  logic [7:0] mode0_q;
  // shadows of lo setup and mode 0, rebuilt from writes
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lo_setup_q <= DMS_SETUP_RESET;
      mode0_q <= DMS_LO_MODE_SLEEP;
    end else if (reg_we_i) begin
      if (reg_addr_i == DMS_LO_SETUP_OFS) lo_setup_q <= reg_wdata_i;
      if (reg_addr_i == DMS_LO_MODE_FIRST_OFS) mode0_q <= reg_wdata_i;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // read request without a write in the same cycle
  sequence s_rd(a);
    reg_re_i && !reg_we_i && reg_addr_i == a;
  endsequence
  // soft lo reset while lo is not linked to receiver sleep
  sequence s_soft_lo_rst;
    reg_we_i && reg_addr_i == DMS_SOFT_PULSE_OFS && reg_wdata_i[3] && !lo_setup_q[6];
  endsequence
  property p_rd_lat; reg_re_i |-> ##2 reg_rvalid_o; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_rd_cause; reg_rvalid_o |-> $past(reg_re_i, 2); endproperty
  a_rd_cause: assert property (p_rd_cause) else $error("stray read answer");
  property p_rd_idle; !reg_rvalid_o |-> reg_rdata_o == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_setup_rb; s_rd(DMS_LO_SETUP_OFS) |-> ##2 reg_rdata_o == $past(lo_setup_q, 2);
  endproperty
  a_setup_rb: assert property (p_setup_rb) else $error("lo setup readback");
  property p_soft_rd; s_rd(DMS_SOFT_PULSE_OFS) |-> ##2 reg_rdata_o == 8'h00; endproperty
  a_soft_rd: assert property (p_soft_rd) else $error("soft pulse reads");
  property p_soft_rst; s_soft_lo_rst |-> ##5 lo_ctrl_o == mode0_q; endproperty
  a_soft_rst: assert property (p_soft_rst) else $error("soft lo reset");
  property p_band_act;
    lo_band_active_o == {&lo_ctrl_o[6:5], &lo_ctrl_o[4:3], &lo_ctrl_o[2:1]};
  endproperty
  a_band_act: assert property (p_band_act) else $error("band active");
  property p_band_slp;
    lo_band_sleep_o == {~|lo_ctrl_o[6:5], ~|lo_ctrl_o[4:3], ~|lo_ctrl_o[2:1]};
  endproperty
  a_band_slp: assert property (p_band_slp) else $error("band sleep");
endmodule
bind dms_sequencer_top dms_seq_checker i_dms_seq_checker (.clk_i(clk_i),
  .reset_n_i(reset_n_i), .lo_reset_pin_i(lo_reset_pin_i), .lo_advance_pin_i(lo_advance_pin_i),
  .rcv_reset_pin_i(rcv_reset_pin_i), .rcv_advance_pin_i(rcv_advance_pin_i),
  .reg_addr_i(reg_addr_i), .reg_we_i(reg_we_i), .reg_wdata_i(reg_wdata_i),
  .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
  .lo_ctrl_o(lo_ctrl_o), .lo_band_active_o(lo_band_active_o),
  .lo_band_sleep_o(lo_band_sleep_o), .rcv_ctrl_o(rcv_ctrl_o));

// [test/dms_array_ctl.sv]
// ===========================================================================
// dms_array_ctl: outside array controller driving the four pulse pins
// ===========================================================================
// pins: 0 lo reset, 1 lo advance, 2 rcv reset, 3 rcv advance
`timescale 1ns/10ps
module dms_array_ctl (
  input wire logic clk_i,
  output logic [3:0] pins_o
);
  initial pins_o = 4'h0;
  // levels held eight cycles
  // long levels let the synchroniser see every edge
  task automatic edge_to(input int idx, input logic lvl);
    @(negedge clk_i);
    pins_o[idx] = lvl;
    repeat (8) @(negedge clk_i);
  endtask
  task automatic pulse(input int idx);
    edge_to(idx, 1'b1);
    edge_to(idx, 1'b0);
  endtask
endmodule

// [test/dms_sequencer_top_test.sv]
// ===========================================================================
// dms_sequencer_top_test: directed bench for the dual mode sequencer
// ===========================================================================
// expects dms_array_ctl as pin partner and the bound checker
`timescale 1ns/10ps
module dms_sequencer_top_test;
  import dms_pkg::*;
  logic clk, reset_n, we, re, rvalid;
  logic [7:0] addr, wdata, rdata, lo_ctrl;
  logic [3:0] pins;
  logic [2:0] act, slp;
  logic [23:0] rcv;
  int errors = 0, n_compared = 0;
  initial clk = 1'b0;
  always #2.5 clk = ~clk;
  dms_sequencer_top i_dms_sequencer_top (.clk_i(clk), .reset_n_i(reset_n),
    .lo_reset_pin_i(pins[0]), .lo_advance_pin_i(pins[1]), .rcv_reset_pin_i(pins[2]),
    .rcv_advance_pin_i(pins[3]), .reg_addr_i(addr), .reg_we_i(we), .reg_wdata_i(wdata),
    .reg_re_i(re), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .lo_ctrl_o(lo_ctrl),
    .lo_band_active_o(act), .lo_band_sleep_o(slp), .rcv_ctrl_o(rcv));
  dms_array_ctl i_dms_array_ctl (.clk_i(clk), .pins_o(pins));
  task automatic chk(input string name, input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  // write then let any soft pulse run through to the outputs
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    we = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    we = 1'b0;
    repeat (8) @(negedge clk);
  endtask
  // read answer comes one edge after the request edge
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    re = 1'b1;
    addr = a;
    @(negedge clk);
    re = 1'b0;
    @(posedge clk);
    #1 chk("rdata", {16'h0, rdata}, {16'h0, exp});
  endtask
  task automatic clo(input logic [7:0] exp);
    chk("lo_ctrl", {16'h0, lo_ctrl}, {16'h0, exp});
  endtask
  task automatic t_regs;
    for (int i = 0; i < 16; i++) rd(8'h70 + 8'(i), DMS_LO_MODE_INIT[i*8+:8]);
    wr(8'h7F, 8'h5A);
    rd(8'h7F, 8'h5A);
    rd(8'h30, 8'h00);
    rd(DMS_SOFT_PULSE_OFS, 8'h00);
    wr(8'h43, 8'h11);
    wr(8'h44, 8'h22);
    wr(8'h45, 8'h33);
    rd(8'h45, 8'h33);
    wr(8'h1A, 8'h10);
    wr(8'h22, 8'h12);
    wr(8'h23, 8'h30);
    rd(8'h22, 8'h12);
    wr(DMS_RCV_SETUP_OFS, 8'h90);
    rd(DMS_RCV_SETUP_OFS, 8'h90);
    wr(DMS_LO_SETUP_OFS, 8'h92);
  endtask
  // bypassed loop of three states: new mode shows before the fall
  task automatic t_lo_loop;
    logic [7:0] seq [4] = '{8'h2B, 8'hFA, 8'h7A, 8'h2B};
    wr(DMS_SOFT_PULSE_OFS, 8'h08);
    clo(8'h00);
    for (int i = 0; i < 4; i++) begin
      i_dms_array_ctl.edge_to(1, 1'b1);
      clo(seq[i]);
      i_dms_array_ctl.edge_to(1, 1'b0);
    end
  endtask
  task automatic t_latch;
    wr(DMS_LO_SETUP_OFS, 8'h82);
    i_dms_array_ctl.edge_to(1, 1'b1);
    clo(8'h2B);
    i_dms_array_ctl.edge_to(1, 1'b0);
    clo(8'hFA);
    i_dms_array_ctl.pulse(0);
    clo(8'h00);
    wr(DMS_LO_SETUP_OFS, 8'h02);
    i_dms_array_ctl.pulse(1);
    clo(8'h00);
    wr(DMS_SOFT_PULSE_OFS, 8'h04);
    clo(8'h2B);
  endtask
  // one link bit: lo linked to receiver sleep, with hold
  task automatic t_sleep;
    wr(DMS_LO_SETUP_OFS, 8'hF2);
    clo(8'h00);
    wr(DMS_SOFT_PULSE_OFS, 8'h04);
    i_dms_array_ctl.pulse(1);
    i_dms_array_ctl.pulse(3);
    chk("rcv_ctrl", rcv, 24'h332211);
    clo(8'h2B);
    i_dms_array_ctl.pulse(3);
    chk("rcv_ctrl", rcv, 24'h332211);
    i_dms_array_ctl.pulse(0);
    clo(8'h00);
    i_dms_array_ctl.pulse(2);
    chk("rcv_ctrl", rcv, 24'h000000);
    wr(DMS_SOFT_PULSE_OFS, 8'h01);
    chk("rcv_ctrl", rcv, 24'h332211);
    wr(DMS_SOFT_PULSE_OFS, 8'h02);
    chk("rcv_ctrl", rcv, 24'h000000);
  endtask
  task automatic summarize;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // watchdog well beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    summarize();
  end
  initial begin
    {reset_n, we, re, addr, wdata} = 19'h0;
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    t_regs();
    t_lo_loop();
    t_latch();
    t_sleep();
    summarize();
  end
endmodule
